/* asp_pkg.sv */
package asp_pkg;

    // ==========================================================
    // Word and counter layout
    localparam int                 ASP_WORD_BITS = 16;
    localparam int                 ASP_CNT_W     = 5;
    localparam logic [ASP_CNT_W-1:0] ASP_CNT_ZERO  = 5'h00;
    localparam logic [ASP_CNT_W-1:0] ASP_CNT_ONE   = 5'h01;
    localparam logic [ASP_CNT_W-1:0] ASP_LAST_BIT  = 5'h0F;  // Index of 16th latched bit
    localparam logic [ASP_CNT_W-1:0] ASP_PULSES    = 5'h10;  // Gated clock pulses per frame

    // ==========================================================
    // Mode select pin codes {hi, lo}
    localparam logic [1:0] ASP_SEL_SPI   = 2'h0;
    localparam logic [1:0] ASP_SEL_EDGE  = 2'h1;
    localparam logic [1:0] ASP_SEL_GATED = 2'h2;
    localparam logic [1:0] ASP_SEL_FREE  = 2'h3;

    // ==========================================================
    // Types
    typedef logic [ASP_WORD_BITS-1:0] asp_word_t;

    localparam asp_word_t ASP_WORD_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        ASP_MODE_TWO_WIRE,
        ASP_MODE_SPI,
        ASP_MODE_EDGE,
        ASP_MODE_GATED,
        ASP_MODE_FREE
    } asp_mode_t;

    typedef enum logic [1:0] {
        ASP_GEN_IDLE,
        ASP_GEN_WAIT,
        ASP_GEN_RUN
    } asp_gen_t;

    // Two-way pin drive: level and output enable
    typedef struct packed {
        logic drv;
        logic oe;
    } asp_pin_t;

    localparam asp_pin_t ASP_PIN_OFF = 2'h0;

    // Pin and cross-domain inputs seen by the link clock
    typedef struct packed {
        logic sel_hi;
        logic sel_lo;
        logic pol;
        logic two_wire;
        logic sclk;
        logic fsync;
        logic din;
        logic tx_req;
        logic start;
    } asp_link_in_t;

    localparam asp_link_in_t ASP_LINK_IN_RST = 9'h008;  // Sync reads idle high, no false frame

endpackage

/* asp_serial_port.sv */
`timescale 1ns/1ps

// Functional notes
// - Modes 1-3: polarity 0 shifts out on rising, latches on falling; 1 swaps.
// - Modes 4-5: polarity 0 shifts out on falling, latches on rising; 1 swaps.
// - Modes 4-5: first bit presented at frame sync fall, rest on clock edges.
// - Modes 1-3: frame sync, clock level and polarity decide MSB launch.
// - Polarity high, sync falls with clock low: MSB goes out at once.
// - Polarity low, sync falls with clock high: MSB goes out at once.
// - Frame sync high clears shift register and abandons partial transfer.
// - After that, next frame starts fresh at bit one of sixteen.
// - Select pins 00 mode 2/1, 01 mode 3, 10 mode 4, 11 mode 5.
// - Mode 2 is the default mode.
// - Mode 1 only when control option set and both select pins low.
// - Modes 4-5: device drives serial clock and frame sync.
// - Mode 4: gated clock of exactly sixteen pulses per frame.
// - Mode 5: free-running serial clock.
// - Modes 4-5 serial clock derived from master clock, gated in mode 4.
module asp_serial_port
    import asp_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      rst_b,
    input  wire logic      master_clock_in,
    input  wire logic      mode_select_hi,
    input  wire logic      mode_select_lo,
    input  wire logic      polarity,
    input  wire logic      two_wire_sel,
    input  wire asp_word_t tx_data,
    input  wire logic      tx_load,
    output logic           tx_ready,
    input  wire logic      conv_start,
    output asp_word_t      rx_data,
    output logic           rx_valid,
    output logic           frame_busy,
    input  wire logic      sclk_i,
    output asp_pin_t       sclk_pin,
    input  wire logic      sync_i,
    output asp_pin_t       sync_pin,
    input  wire logic      din_i,
    output asp_pin_t       din_pin,
    output asp_pin_t       dout_pin
);

    // ==========================================================
    // System clock side: word handshake, start toggle, result capture
    logic      tx_req_tgl;
    asp_word_t tx_buf;
    logic      start_tgl;
    logic [1:0] ack_sync;
    logic [2:0] rx_sync;
    logic [1:0] busy_sync;

    // Link side registers read across the boundary
    logic      ack_tgl;
    logic      rx_tgl;
    asp_word_t rx_word_l;
    logic      busy_l;

    wire tx_take    = tx_load & tx_ready;
    wire next_ready = ~tx_take & (ack_sync[1] == tx_req_tgl);
    wire rx_new     = rx_sync[1] ^ rx_sync[2];

    // Word is held in tx_buf until the link side acknowledges it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_req_tgl <= 1'b0;
            tx_buf     <= ASP_WORD_ZERO;
            tx_ready   <= 1'b1;
            start_tgl  <= 1'b0;
        end else begin
            tx_req_tgl <= tx_req_tgl ^ tx_take;
            tx_buf     <= tx_take ? tx_data : tx_buf;
            tx_ready   <= next_ready;
            start_tgl  <= start_tgl ^ conv_start;
        end
    end

    // Toggle synchronisers back from the link; rx_word_l is stable for a frame
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_sync   <= 2'h0;
            rx_sync    <= 3'h0;
            busy_sync  <= 2'h0;
            rx_data    <= ASP_WORD_ZERO;
            rx_valid   <= 1'b0;
            frame_busy <= 1'b0;
        end else begin
            ack_sync   <= {ack_sync[0], ack_tgl};
            rx_sync    <= {rx_sync[1:0], rx_tgl};
            busy_sync  <= {busy_sync[0], busy_l};
            rx_data    <= rx_new ? rx_word_l : rx_data;
            rx_valid   <= rx_new;
            frame_busy <= busy_sync[1];
        end
    end

    // ==========================================================
    // Link side: reset release and input synchronisers
    logic [1:0]   lrst_pipe;
    asp_link_in_t pin_raw;
    asp_link_in_t pin_meta;
    asp_link_in_t pin_s;
    logic         sclk_q;
    logic         req_q;
    logic         start_q;

    wire lrst_b = lrst_pipe[1];

    assign pin_raw = {mode_select_hi, mode_select_lo, polarity, two_wire_sel,
                      sclk_i, sync_i, din_i, tx_req_tgl, start_tgl};

    // Reset asserts at once, releases on the master clock
    always_ff @(posedge master_clock_in or negedge rst_b) begin
        if (!rst_b) begin
            lrst_pipe <= 2'h0;
        end else begin
            lrst_pipe <= {lrst_pipe[0], 1'b1};
        end
    end

    // Two flops before any logic; pin_meta feeds pin_s only
    always_ff @(posedge master_clock_in or negedge lrst_b) begin
        if (!lrst_b) begin
            pin_meta <= ASP_LINK_IN_RST;
            pin_s    <= ASP_LINK_IN_RST;
            sclk_q   <= 1'b0;
            req_q    <= 1'b0;
            start_q  <= 1'b0;
        end else begin
            pin_meta <= pin_raw;
            pin_s    <= pin_meta;
            sclk_q   <= pin_s.sclk;
            req_q    <= pin_s.tx_req;
            start_q  <= pin_s.start;
        end
    end

    // ==========================================================
    // Mode decode
    wire [1:0] sel = {pin_s.sel_hi, pin_s.sel_lo};
    asp_mode_t mode;

    assign mode = (sel == ASP_SEL_EDGE)  ? ASP_MODE_EDGE  :
                  (sel == ASP_SEL_GATED) ? ASP_MODE_GATED :
                  (sel == ASP_SEL_FREE)  ? ASP_MODE_FREE  :
                  pin_s.two_wire         ? ASP_MODE_TWO_WIRE :
                                           ASP_MODE_SPI;

    wire pol       = pin_s.pol;
    wire m_two     = (mode == ASP_MODE_TWO_WIRE);
    wire m_edge    = (mode == ASP_MODE_EDGE);
    wire m_gated   = (mode == ASP_MODE_GATED);
    wire m_free    = (mode == ASP_MODE_FREE);
    wire ext_mode  = ~(m_gated | m_free);

    // ==========================================================
    // Host-clocked modes 1-3
    logic ext_act;
    logic ext_done;
    logic m1_read;
    logic first_pend;

    wire sclk_rise = pin_s.sclk & ~sclk_q;
    wire sclk_fall = ~pin_s.sclk & sclk_q;
    wire out_edge  = pol ? sclk_fall : sclk_rise;
    wire in_edge   = pol ? sclk_rise : sclk_fall;
    wire ext_abort = ext_mode & pin_s.fsync;
    wire ext_go    = ext_mode & ~pin_s.fsync & ~ext_act & ~ext_done;
    // Sync edge launches MSB only when the clock sits at the right level
    wire launch_now = pol ? ~pin_s.sclk : pin_s.sclk;

    // ==========================================================
    // Self-clocked modes 4-5
    asp_gen_t             gstate;
    asp_gen_t             next_gstate;
    logic [ASP_CNT_W-1:0] gcnt;
    logic [1:0]           lat_d;

    wire gclk      = sclk_pin.drv;
    wire g_run     = (gstate == ASP_GEN_RUN);
    // Free clock never stops; gated clock runs only inside a frame
    wire g_toggle  = m_free | g_run | (gclk != pol);
    wire g_latch   = ~ext_mode & g_run & g_toggle & (gclk == pol);
    wire g_shift   = ~ext_mode & g_run & g_toggle & (gclk != pol);
    wire g_begin   = (gstate == ASP_GEN_WAIT) & (m_gated | (gclk != pol));
    wire g_end     = g_shift & (gcnt == ASP_PULSES);
    wire start_ev  = pin_s.start ^ start_q;

    // Frame sequencer for the generated clock and sync
    always_comb begin
        next_gstate = gstate;
        case (gstate)
            ASP_GEN_IDLE: begin
                if (~ext_mode & start_ev) begin
                    next_gstate = ASP_GEN_WAIT;
                end
            end
            ASP_GEN_WAIT: begin
                if (ext_mode) begin
                    next_gstate = ASP_GEN_IDLE;
                end else if (g_begin) begin
                    next_gstate = ASP_GEN_RUN;
                end
            end
            ASP_GEN_RUN: begin
                if (ext_mode | g_end) begin
                    next_gstate = ASP_GEN_IDLE;
                end
            end
            default: begin
                next_gstate = ASP_GEN_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Shared shift datapath
    asp_word_t            tx_sr;
    asp_word_t            rx_sr;
    asp_word_t            tx_next;
    logic [ASP_CNT_W-1:0] rx_cnt;

    // Generated-clock samples wait two cycles to match the input synchroniser
    wire bit_edge   = ext_mode ? (ext_act & in_edge) : lat_d[1];
    wire rx_full    = bit_edge & (rx_cnt == ASP_LAST_BIT);
    wire ext_wrap   = ext_mode & rx_full;
    wire deliver    = rx_full & ~(m_two & m1_read);
    wire req_ev     = pin_s.tx_req ^ req_q;
    wire frame_load = ext_go | g_begin | (ext_wrap & ~m_edge);
    wire tx_shift   = ext_mode ? (ext_act & out_edge & ~first_pend &
                                  ~(m_two & ~m1_read))
                               : g_shift;
    wire clr_cnt    = ext_abort | ext_go | g_begin;

    wire asp_word_t next_rx_sr = ext_abort ? ASP_WORD_ZERO :
                                 bit_edge  ? {rx_sr[ASP_WORD_BITS-2:0], pin_s.din} :
                                             rx_sr;
    wire asp_word_t next_tx_sr = ext_abort  ? ASP_WORD_ZERO :
                                 frame_load ? tx_next :
                                 tx_shift   ? {tx_sr[ASP_WORD_BITS-2:0], 1'b0} :
                                              tx_sr;
    wire [ASP_CNT_W-1:0] next_rx_cnt = clr_cnt  ? ASP_CNT_ZERO :
                                       rx_full  ? ASP_CNT_ZERO :
                                       bit_edge ? rx_cnt + ASP_CNT_ONE :
                                                  rx_cnt;

    wire next_ext_act  = ext_abort | ~ext_mode      ? 1'b0 :
                         ext_go                     ? 1'b1 :
                         (ext_wrap & m_edge)        ? 1'b0 : ext_act;
    wire next_ext_done = ext_abort | ~ext_mode      ? 1'b0 :
                         (ext_wrap & m_edge)        ? 1'b1 : ext_done;
    wire next_m1_read  = ext_abort | ~ext_mode      ? 1'b0 :
                         (ext_wrap & m_two)         ? ~m1_read : m1_read;
    wire next_first    = frame_load                 ? ~(ext_go & launch_now) :
                         (ext_act & out_edge)       ? 1'b0 : first_pend;

    // Host-side state of modes 1-3 and shift registers
    always_ff @(posedge master_clock_in or negedge lrst_b) begin
        if (!lrst_b) begin
            ext_act    <= 1'b0;
            ext_done   <= 1'b0;
            m1_read    <= 1'b0;
            first_pend <= 1'b1;
            tx_sr      <= ASP_WORD_ZERO;
            rx_sr      <= ASP_WORD_ZERO;
            rx_cnt     <= ASP_CNT_ZERO;
        end else begin
            ext_act    <= next_ext_act;
            ext_done   <= next_ext_done;
            m1_read    <= next_m1_read;
            first_pend <= next_first;
            tx_sr      <= next_tx_sr;
            rx_sr      <= next_rx_sr;
            rx_cnt     <= next_rx_cnt;
        end
    end

    // Generator state, pulse count and sample delay
    always_ff @(posedge master_clock_in or negedge lrst_b) begin
        if (!lrst_b) begin
            gstate <= ASP_GEN_IDLE;
            gcnt   <= ASP_CNT_ZERO;
            lat_d  <= 2'h0;
        end else begin
            gstate <= next_gstate;
            gcnt   <= g_begin ? ASP_CNT_ZERO : (g_latch ? gcnt + ASP_CNT_ONE : gcnt);
            lat_d  <= {lat_d[0], g_latch};
        end
    end

    // Crossing words: tx_next taken on request, rx word held with a toggle
    always_ff @(posedge master_clock_in or negedge lrst_b) begin
        if (!lrst_b) begin
            tx_next   <= ASP_WORD_ZERO;
            ack_tgl   <= 1'b0;
            rx_word_l <= ASP_WORD_ZERO;
            rx_tgl    <= 1'b0;
            busy_l    <= 1'b0;
        end else begin
            tx_next   <= req_ev ? tx_buf : tx_next;
            ack_tgl   <= ack_tgl ^ req_ev;
            rx_word_l <= deliver ? next_rx_sr : rx_word_l;
            rx_tgl    <= rx_tgl ^ deliver;
            busy_l    <= next_ext_act | (next_gstate != ASP_GEN_IDLE);
        end
    end

    // ==========================================================
    // Pin drivers, all registered; clock and sync driven only in modes 4-5
    wire sync_oe_ext = (mode == ASP_MODE_SPI | m_edge) & ~pin_s.fsync;

    always_ff @(posedge master_clock_in or negedge lrst_b) begin
        if (!lrst_b) begin
            sclk_pin <= ASP_PIN_OFF;
            sync_pin <= ASP_PIN_OFF;
            din_pin  <= ASP_PIN_OFF;
            dout_pin <= ASP_PIN_OFF;
        end else begin
            sclk_pin.drv <= g_toggle ? ~gclk : gclk;
            sclk_pin.oe  <= ~ext_mode;
            sync_pin.drv <= (next_gstate != ASP_GEN_RUN);
            sync_pin.oe  <= ~ext_mode;
            din_pin.drv  <= next_tx_sr[ASP_WORD_BITS-1];
            din_pin.oe   <= m_two & next_ext_act & next_m1_read;
            dout_pin.drv <= next_tx_sr[ASP_WORD_BITS-1];
            dout_pin.oe  <= ext_mode ? sync_oe_ext : (next_gstate == ASP_GEN_RUN);
        end
    end

endmodule

/* asp_serial_port_assertions.sv */
`timescale 1ns/1ps
// ========
// Link-side checks on the serial pins
module asp_serial_port_chk
    import asp_pkg::*;
(
    input wire logic     rst_b,
    input wire logic     master_clock_in,
    input wire logic     mode_select_hi,
    input wire logic     mode_select_lo,
    input wire logic     polarity,
    input wire logic     two_wire_sel,
    input wire logic     sync_i,
    input wire asp_pin_t sclk_pin,
    input wire asp_pin_t sync_pin,
    input wire asp_pin_t din_pin,
    input wire asp_pin_t dout_pin
);
    // Pins pass synchronisers, so each check waits for 8 steady cycles
    logic [ASP_CNT_W-1:0] pulse_cnt;
    logic                 sclk_prev;
    wire                  mode_gated = mode_select_hi && !mode_select_lo;
    wire                  leave_idle = !sync_pin.drv && sclk_pin.drv != polarity
                                       && sclk_prev == polarity;

    // Departures from the idle level while a generated frame runs
    always_ff @(posedge master_clock_in or negedge rst_b) begin
        if (!rst_b) begin
            pulse_cnt <= ASP_CNT_ZERO;
            sclk_prev <= 1'h0;
        end else begin
            sclk_prev <= sclk_pin.drv;
            pulse_cnt <= sync_pin.drv ? ASP_CNT_ZERO : pulse_cnt + {4'h0, leave_idle};
        end
    end

    default clocking @(posedge master_clock_in); endclocking
    default disable iff (!rst_b);

    a_host_no_drive: assert property ((!mode_select_hi)[*8]
        |-> !sclk_pin.oe && !sync_pin.oe) else $error("Clock or sync driven in host mode");
    a_dev_drives: assert property (mode_select_hi[*8]
        |-> sclk_pin.oe && sync_pin.oe) else $error("Clock or sync not driven");
    a_free_clock: assert property ((mode_select_hi && mode_select_lo)[*8]
        |-> sclk_pin.drv != $past(sclk_pin.drv)) else $error("Free clock stalled");
    a_gated_idle: assert property ((mode_gated && sync_pin.drv)[*8]
        |-> sclk_pin.drv == polarity) else $error("Gated clock not idle");
    a_gated_count: assert property (mode_gated[*8] ##0 $rose(sync_pin.drv)
        |-> pulse_cnt == ASP_PULSES) else $error("Gated frame pulse count wrong");
    a_sync_launch: assert property (mode_select_hi[*8] ##0 $fell(sync_pin.drv)
        |-> dout_pin.oe) else $error("First bit not driven at sync fall");
    a_dout_quiet: assert property ((!mode_select_hi && sync_i)[*8]
        |-> !dout_pin.oe) else $error("Data out driven with sync high");
    a_two_wire_only: assert property ((!two_wire_sel)[*8]
        |-> !din_pin.oe) else $error("Data in driven outside two-wire mode");
endmodule

bind asp_serial_port asp_serial_port_chk i_asp_serial_port_chk (
    .rst_b(rst_b), .master_clock_in(master_clock_in), .mode_select_hi(mode_select_hi),
    .mode_select_lo(mode_select_lo), .polarity(polarity), .two_wire_sel(two_wire_sel),
    .sync_i(sync_i), .sclk_pin(sclk_pin), .sync_pin(sync_pin), .din_pin(din_pin),
    .dout_pin(dout_pin)
);

/* asp_host.sv */
`timescale 1ns/1ps
// ========
// Host serial port: master in host-clocked modes, slave otherwise
module asp_host
    import asp_pkg::*;
#(
    parameter int HALF_NS = 480
)(
    output logic      sclk,
    output logic      sync_b,
    output logic      din,
    input  wire logic sclk_w,
    input  wire logic sync_w,
    input  wire logic din_w,
    input  wire logic dout_w
);
    // Idle: clock high, no frame
    initial begin
        sclk   = 1'h1;
        sync_b = 1'h1;
        din    = 1'h0;
    end

    // Host-clocked frame; fewer than 16 bits aborts it; with rd, bits past 16 read the two-way line
    task automatic host_frame(input asp_word_t w, input logic pol, input int nb,
                              input logic rd, output asp_word_t r);
        r    = ASP_WORD_ZERO;
        sclk = ~pol;
        din  = w[15];
        #(HALF_NS);
        sync_b = 1'h0; // Clock idles so the sync fall launches the first bit
        #(HALF_NS);
        for (int i = 0; i < nb; i++) begin
            sclk = pol;
            r    = {r[14:0], (rd && i > 15) ? din_w : dout_w};
            #(HALF_NS);
            sclk = ~pol;
            if (i < 15) din = w[14-i];
            #(HALF_NS);
        end
        sync_b = 1'h1;
        din    = ~din; // Released line must not keep the last bit
        #(4*HALF_NS);
    endtask

    // Wait for the generated clock to reach a level
    task automatic lvl(input logic v);
        do @(sclk_w); while (sclk_w !== v);
    endtask

    // Slave frame on the device's own clock and sync
    task automatic slave_frame(input asp_word_t w, input logic pol, output asp_word_t r);
        r = ASP_WORD_ZERO;
        @(negedge sync_w);
        din = w[15];
        for (int i = 0; i < 16; i++) begin
            lvl(~pol);
            r = {r[14:0], dout_w};
            if (i < 15) begin
                lvl(pol);
                din = w[14-i];
            end
        end
        din = ~din;
    endtask
endmodule

/* tb_asp_serial_port.sv */
`timescale 1ns/1ps
module tb_asp_serial_port
    import asp_pkg::*;
;
    logic      sys_clk, rst_b, mclk, sel_hi, sel_lo, pol, two_wire, tx_load, conv_start;
    logic      tx_ready, rx_valid, frame_busy, h_sclk, h_sync_b, h_din;
    asp_word_t tx_data, rx_data, r;
    asp_pin_t  sclk_pin, sync_pin, din_pin, dout_pin;
    int        mismatches, n_compared, n_rx, n0;
    asp_word_t tbl [4] = '{16'h8001, 16'h7FFE, 16'hC3A5, 16'h5A3C};
    // Pin wires: device wins when it enables its driver
    wire       sclk_w = sclk_pin.oe ? sclk_pin.drv : h_sclk;
    wire       sync_w = sync_pin.oe ? sync_pin.drv : h_sync_b;
    wire       din_w  = din_pin.oe ? din_pin.drv : h_din;
    wire       dout_w = dout_pin.oe ? dout_pin.drv : 1'hZ;

    // ========
    // Clocks, unrelated in phase
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        mclk = 1'h0;
        #7.3;
        forever #24 mclk = ~mclk;
    end
    always @(posedge sys_clk) if (rx_valid === 1'h1) n_rx++;

    asp_serial_port i_asp_serial_port (
        .sys_clk(sys_clk), .rst_b(rst_b), .master_clock_in(mclk), .mode_select_hi(sel_hi),
        .mode_select_lo(sel_lo), .polarity(pol), .two_wire_sel(two_wire), .tx_data(tx_data),
        .tx_load(tx_load), .tx_ready(tx_ready), .conv_start(conv_start), .rx_data(rx_data),
        .rx_valid(rx_valid), .frame_busy(frame_busy), .sclk_i(sclk_w), .sclk_pin(sclk_pin),
        .sync_i(sync_w), .sync_pin(sync_pin), .din_i(din_w), .din_pin(din_pin),
        .dout_pin(dout_pin));
    asp_host i_asp_host (.sclk(h_sclk), .sync_b(h_sync_b), .din(h_din), .sclk_w(sclk_w),
        .sync_w(sync_w), .din_w(din_w), .dout_w(dout_w));

    // ========
    // Shared steps
    task automatic chk(input asp_word_t got, input asp_word_t exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic setmode(input logic hi, input logic lo, input logic tw, input logic p);
        @(posedge sys_clk);
        #1;
        {sel_hi, sel_lo, two_wire, pol} = {hi, lo, tw, p};
        repeat (12) @(posedge mclk);
    endtask
    task automatic load(input asp_word_t w);
        int i = 0;
        do begin
            @(posedge sys_clk);
            #1;
            i++;
        end while (tx_ready !== 1'h1 && i < 400);
        chk(tx_ready, 16'h0001);
        tx_data = w;
        tx_load = 1'h1;
        @(posedge sys_clk);
        #1;
        tx_load = 1'h0;
        chk(tx_ready, ASP_WORD_ZERO);
        repeat (8) @(posedge mclk);
        n0 = n_rx;
    endtask
    // Exactly one word delivered since the load, and the right one
    task automatic rx_check(input asp_word_t w);
        repeat (12) @(posedge mclk);
        chk(asp_word_t'(n_rx - n0), 16'h0001);
        chk(rx_data, w);
    endtask

    // ========
    // Scenarios
    task automatic t_host(input logic lo, input logic p, input asp_word_t w);
        setmode(1'h0, lo, 1'h0, p);
        load(w);
        i_asp_host.host_frame(~w, p, 16, 1'h0, r);
        chk(r, w);
        rx_check(~w);
    endtask
    task automatic t_abort();
        int k;
        setmode(1'h0, 1'h0, 1'h0, 1'h0);
        load(16'h1234);
        k = n0;
        // Busy inside the cut frame, idle once sync has gone high
        fork
            i_asp_host.host_frame(16'hFFFF, 1'h0, 7, 1'h0, r);
            begin
                repeat (60) @(posedge mclk);
                chk(frame_busy, 16'h0001);
            end
        join
        chk(frame_busy, ASP_WORD_ZERO);
        load(16'h4002); // New word loaded for the frame after the aborted one
        n0 = k;
        i_asp_host.host_frame(16'h6C93, 1'h0, 16, 1'h0, r);
        chk(r, 16'h4002);
        rx_check(16'h6C93);
    endtask
    task automatic t_dev(input logic lo, input logic p, input asp_word_t w);
        setmode(1'h1, lo, 1'h0, p);
        load(w);
        fork
            i_asp_host.slave_frame(~w, p, r);
            begin
                @(posedge sys_clk);
                #1;
                conv_start = 1'h1;
                @(posedge sys_clk);
                #1;
                conv_start = 1'h0;
            end
        join
        chk(r, w);
        rx_check(~w);
    endtask
    task automatic t_two_wire();
        setmode(1'h0, 1'h0, 1'h1, 1'h0);
        load(16'h9C6E);
        // Read phase follows the 16 write bits, so write and read share one 32-bit frame
        i_asp_host.host_frame(16'h2DB1, 1'h0, 32, 1'h1, r);
        chk(r, 16'h9C6E);
        rx_check(16'h2DB1);
    endtask

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Hang guard, well beyond the expected run time
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        {rst_b, sel_hi, sel_lo, pol, two_wire, tx_load, conv_start} = 7'h00;
        tx_data = ASP_WORD_ZERO;
        repeat (16) @(posedge sys_clk);
        #1;
        rst_b = 1'h1;
        repeat (10) @(posedge mclk);
        for (int p = 0; p < 2; p++) begin
            for (int lo = 0; lo < 2; lo++) begin
                t_host(lo[0], p[0], tbl[2*p+lo]);
            end
        end
        t_abort();
        for (int p = 0; p < 2; p++) begin
            for (int lo = 0; lo < 2; lo++) begin
                t_dev(lo[0], p[0], tbl[3-2*p-lo]);
            end
        end
        t_two_wire();
        report_and_stop();
    end
endmodule
